// ---- core/pate_pkg.sv ----
package pate_pkg;
  // register port
  localparam int REG_AW = 5;
  localparam logic [7:0] REG_RST = 8'h00;
  // general channel local index; channel n sits at n * 8
  localparam logic [2:0] OFS_CTL = 3'h0;
  localparam logic [2:0] OFS_IO = 3'h1;
  localparam logic [2:0] OFS_HI = 3'h2;
  localparam logic [2:0] OFS_START = 3'h3;
  localparam logic [2:0] OFS_END = 3'h4;
  // converter channel
  localparam logic [4:0] OFS_ADC_BASE = 5'h10;
  localparam logic [4:0] OFS_ADC_CTL = 5'h11;
  localparam logic [4:0] OFS_ADC_STAT = 5'h12;
  localparam logic [2:0] ADC_IN_FIRST = 3'h0;
  // address forming
  localparam logic [3:0] PERIPH_NIBBLE = 4'hf;
  localparam logic [11:0] STEP_BYTE = 12'h001;
  localparam logic [11:0] STEP_WORD = 12'h002;

  typedef struct packed {
    logic en;
    logic loop;
    logic dir;
    logic irq_en;
    logic word;
    logic [2:0] trig;
  } pate_gctl_t;

  typedef struct packed {
    pate_gctl_t ctl;
    logic [7:0] io;
    logic [7:0] hi;
    logic [7:0] start;
    logic [7:0] fin;
  } pate_gregs_t;

  typedef struct packed {
    logic en;
    logic irq_en;
    logic [2:0] rsvd;
    logic [2:0] last_in;
  } pate_actl_t;

  typedef struct packed {
    logic req;
    logic re;
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } pate_sbus_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ASK = 5'b00010,
    S_READ = 5'b00100,
    S_CAP = 5'b01000,
    S_WRITE = 5'b10000
  } pate_state_t;
endpackage

// ---- core/pate_arb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pate_arb #(
  parameter int N = 3
) (
  // requests and grant, lowest index wins
  input wire logic [N-1:0] req,
  output logic [N-1:0] grant
);
  logic [N:0] blocked;

  assign blocked[0] = 1'b0;
  for (genvar i = 0; i < N; i++) begin : g_pri
    assign grant[i] = req[i] && !blocked[i];
    assign blocked[i+1] = blocked[i] || req[i];
  end
endmodule
`default_nettype wire

// ---- core/pate_gen_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
module pate_gen_chan #(
  parameter int TRIG_N = 8
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register writes for this channel
  input wire logic reg_we,
  input wire logic [2:0] reg_idx,
  input wire logic [7:0] reg_wdata,
  // trigger sources and transfer completion
  input wire logic [TRIG_N-1:0] trig_in,
  input wire logic xfer_done,
  // state seen by the engine
  output pate_pkg::pate_gregs_t regs,
  output logic [11:0] cur_addr,
  output logic pending,
  output logic irq
);
  pate_pkg::pate_gregs_t next_regs;
  logic [11:0] next_cur_addr;
  logic next_pending;
  logic next_irq;
  logic at_end;
  logic trig_hit;

  assign at_end = cur_addr == {regs.hi[7:4], regs.fin};
  assign trig_hit = (int'(regs.ctl.trig) < TRIG_N) && trig_in[regs.ctl.trig];

  always_comb begin
    next_regs = regs;
    next_cur_addr = cur_addr;
    next_pending = pending;
    next_irq = 1'b0;
    if (xfer_done) begin
      next_pending = 1'b0;
      if (at_end) begin
        next_cur_addr = {regs.hi[3:0], regs.start};
        next_irq = regs.ctl.irq_en;
        if (!regs.ctl.loop) begin
          next_regs.ctl.en = 1'b0;
        end
      end else if (regs.ctl.word) begin
        next_cur_addr = cur_addr + pate_pkg::STEP_WORD;
      end else begin
        next_cur_addr = cur_addr + pate_pkg::STEP_BYTE;
      end
    end
    if (reg_we) begin
      case (reg_idx)
        pate_pkg::OFS_CTL: next_regs.ctl = pate_pkg::pate_gctl_t'(reg_wdata);
        pate_pkg::OFS_IO: next_regs.io = reg_wdata;
        pate_pkg::OFS_HI: begin
          next_regs.hi = reg_wdata;
          next_cur_addr = {reg_wdata[3:0], regs.start};
        end
        pate_pkg::OFS_START: begin
          next_regs.start = reg_wdata;
          next_cur_addr = {regs.hi[3:0], reg_wdata};
        end
        pate_pkg::OFS_END: next_regs.fin = reg_wdata;
        default: ;
      endcase
    end
    // a trigger in the completing cycle is kept: set beats clear
    if (next_regs.ctl.en && trig_hit) begin
      next_pending = 1'b1;
    end
    if (!next_regs.ctl.en) begin
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regs <= pate_pkg::pate_gregs_t'({5{pate_pkg::REG_RST}});
      cur_addr <= 12'h000;
      pending <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      regs <= next_regs;
      cur_addr <= next_cur_addr;
      pending <= next_pending;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// ---- core/pate_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// - three channels: two general movers, one converter result channel
// - general channel starts only on its selected trigger, then asks the bus
// - after acknowledge, move one byte or word, then release the bus
// - at end address, current address reloads the start address
// - at end address, interrupt request if interrupt enabled
// - at end address in single pass, channel enable clears
// - otherwise current address steps by one byte or two for words
// - peripheral address is nibble f above the peripheral low byte
// - start and end addresses take high nibbles from one register
// - control selects loop, direction, interrupt, size, trigger, enable
// - converter channel starts when a two-byte result is ready
// - after grant converter result is written, then bus released
// - after highest input, input wraps to 0 and converts again
// - on that wrap, interrupt request if enabled
// - otherwise conversion starts on the next higher input
// - converter base register gives top seven destination bits
// - loop enable keeps channel running after the end transfer
// - direction 0 register file to peripheral, 1 the reverse
module pate_engine #(
  parameter int TRIG_N = 8
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [pate_pkg::REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral trigger sources
  input wire logic [TRIG_N-1:0] trig_in,
  // converter
  input wire logic adc_ready,
  input wire logic [15:0] adc_data,
  output logic adc_start,
  output logic [2:0] adc_input,
  // system bus
  input wire logic bus_ack,
  input wire logic [7:0] sys_rdata,
  output var pate_pkg::pate_sbus_t sys_bus,
  // interrupt requests: general 0, general 1, converter
  output logic [2:0] irq_req
);
  pate_pkg::pate_gregs_t g_regs [2];
  logic [11:0] g_cur [2];
  logic [1:0] g_pend;
  logic [1:0] g_irq;
  logic [2:0] grant;
  logic [2:0] done;
  logic xfer_end;

  pate_pkg::pate_state_t state, next_state;
  pate_pkg::pate_sbus_t next_sys_bus;
  logic [2:0] owner, next_owner;
  logic bidx, next_bidx;
  logic [7:0] next_reg_rdata;

  logic [6:0] adc_base, next_adc_base;
  pate_pkg::pate_actl_t adc_ctl, next_adc_ctl;
  logic adc_pend, next_adc_pend;
  logic [15:0] adc_word, next_adc_word;
  logic [2:0] next_adc_input;
  logic next_adc_start;
  logic adc_irq, next_adc_irq;

  pate_pkg::pate_gregs_t gk;
  logic [11:0] ck;
  logic [11:0] src_base, dst_base;
  logic two_bytes;

  // general channels
  for (genvar i = 0; i < 2; i++) begin : g_gen
    pate_gen_chan #(.TRIG_N(TRIG_N)) u_chan (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .reg_we(reg_wr && !reg_addr[4] && (int'(reg_addr[3]) == i)),
      .reg_idx(reg_addr[2:0]),
      .reg_wdata(reg_wdata),
      .trig_in(trig_in),
      .xfer_done(done[i]),
      .regs(g_regs[i]),
      .cur_addr(g_cur[i]),
      .pending(g_pend[i]),
      .irq(g_irq[i])
    );
  end

  pate_arb #(.N(3)) u_arb (
    .req({adc_pend, g_pend}),
    .grant(grant)
  );

  assign done = {3{xfer_end}} & owner;
  assign irq_req = {adc_irq, g_irq};

  // source and destination of the owner's transfer
  assign gk = owner[1] ? g_regs[1] : g_regs[0];
  assign ck = owner[1] ? g_cur[1] : g_cur[0];

  always_comb begin
    src_base = ck;
    dst_base = {pate_pkg::PERIPH_NIBBLE, gk.io};
    two_bytes = gk.ctl.word;
    if (owner[2]) begin
      dst_base = {adc_base, 1'b0, adc_input, 1'b0};
      two_bytes = 1'b1;
    end else if (gk.ctl.dir) begin
      src_base = {pate_pkg::PERIPH_NIBBLE, gk.io};
      dst_base = ck;
    end
  end

  // bus sequencer: one owner per grant, bus held for the whole unit
  always_comb begin
    next_state = state;
    next_sys_bus = sys_bus;
    next_owner = owner;
    next_bidx = bidx;
    xfer_end = 1'b0;
    unique case (state)
      pate_pkg::S_IDLE: begin
        if (|grant) begin
          next_owner = grant;
          next_bidx = 1'b0;
          next_sys_bus.req = 1'b1;
          next_state = pate_pkg::S_ASK;
        end
      end
      pate_pkg::S_ASK: begin
        if (bus_ack) begin
          if (owner[2]) begin
            next_sys_bus.we = 1'b1;
            next_sys_bus.addr = dst_base;
            next_sys_bus.wdata = adc_word[15:8];
            next_state = pate_pkg::S_WRITE;
          end else begin
            next_sys_bus.re = 1'b1;
            next_sys_bus.addr = src_base;
            next_state = pate_pkg::S_READ;
          end
        end
      end
      pate_pkg::S_READ: begin
        next_sys_bus.re = 1'b0;
        next_state = pate_pkg::S_CAP;
      end
      pate_pkg::S_CAP: begin
        next_sys_bus.we = 1'b1;
        next_sys_bus.addr = dst_base + {11'h000, bidx};
        next_sys_bus.wdata = sys_rdata;
        next_state = pate_pkg::S_WRITE;
      end
      pate_pkg::S_WRITE: begin
        next_sys_bus.we = 1'b0;
        if (!bidx && two_bytes) begin
          next_bidx = 1'b1;
          if (owner[2]) begin
            next_sys_bus.we = 1'b1;
            next_sys_bus.addr = dst_base + 12'h001;
            next_sys_bus.wdata = adc_word[7:0];
          end else begin
            next_sys_bus.re = 1'b1;
            next_sys_bus.addr = src_base + 12'h001;
            next_state = pate_pkg::S_READ;
          end
        end else begin
          xfer_end = 1'b1;
          next_sys_bus.req = 1'b0;
          next_state = pate_pkg::S_IDLE;
        end
      end
    endcase
  end

  // converter channel registers and input sequencing
  always_comb begin
    next_adc_base = adc_base;
    next_adc_ctl = adc_ctl;
    next_adc_pend = adc_pend;
    next_adc_word = adc_word;
    next_adc_input = adc_input;
    next_adc_start = 1'b0;
    next_adc_irq = 1'b0;
    if (reg_wr && reg_addr == pate_pkg::OFS_ADC_BASE) begin
      next_adc_base = reg_wdata[6:0];
    end
    if (reg_wr && reg_addr == pate_pkg::OFS_ADC_CTL) begin
      next_adc_ctl = pate_pkg::pate_actl_t'(reg_wdata);
      next_adc_ctl.rsvd = 3'h0;
      if (next_adc_ctl.en && !adc_ctl.en) begin
        next_adc_input = pate_pkg::ADC_IN_FIRST;
        next_adc_start = 1'b1;
      end
    end
    if (done[2]) begin
      next_adc_pend = 1'b0;
      next_adc_start = 1'b1;
      // >= so a lowered count cannot strand the sequence above it
      if (adc_input >= adc_ctl.last_in) begin
        next_adc_input = pate_pkg::ADC_IN_FIRST;
        next_adc_irq = adc_ctl.irq_en;
      end else begin
        next_adc_input = adc_input + 3'h1;
      end
    end
    if (adc_ctl.en && adc_ready) begin
      next_adc_pend = 1'b1;
      next_adc_word = adc_data;
    end
    if (!next_adc_ctl.en) begin
      next_adc_pend = 1'b0;
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd && !reg_addr[4]) begin
      case (reg_addr[2:0])
        pate_pkg::OFS_CTL: next_reg_rdata = g_regs[reg_addr[3]].ctl;
        pate_pkg::OFS_IO: next_reg_rdata = g_regs[reg_addr[3]].io;
        pate_pkg::OFS_HI: next_reg_rdata = g_regs[reg_addr[3]].hi;
        pate_pkg::OFS_START: next_reg_rdata = g_cur[reg_addr[3]][7:0];
        pate_pkg::OFS_END: next_reg_rdata = g_regs[reg_addr[3]].fin;
        default: next_reg_rdata = 8'h00;
      endcase
    end else if (reg_rd) begin
      case (reg_addr)
        pate_pkg::OFS_ADC_BASE: next_reg_rdata = {1'b0, adc_base};
        pate_pkg::OFS_ADC_CTL: next_reg_rdata = adc_ctl;
        pate_pkg::OFS_ADC_STAT: next_reg_rdata =
          {!state[0], adc_pend, 3'h0, adc_input};
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= pate_pkg::S_IDLE;
      sys_bus <= '0;
      owner <= 3'h0;
      bidx <= 1'b0;
      reg_rdata <= pate_pkg::REG_RST;
      adc_base <= 7'h00;
      adc_ctl <= pate_pkg::pate_actl_t'(pate_pkg::REG_RST);
      adc_pend <= 1'b0;
      adc_word <= 16'h0000;
      adc_input <= pate_pkg::ADC_IN_FIRST;
      adc_start <= 1'b0;
      adc_irq <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      sys_bus <= next_sys_bus;
      owner <= next_owner;
      bidx <= next_bidx;
      reg_rdata <= next_reg_rdata;
      adc_base <= next_adc_base;
      adc_ctl <= next_adc_ctl;
      adc_pend <= next_adc_pend;
      adc_word <= next_adc_word;
      adc_input <= next_adc_input;
      adc_start <= next_adc_start;
      adc_irq <= next_adc_irq;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst || !ce);

  a_priority_zero: assert property (
    (state == pate_pkg::S_IDLE && g_pend[0]) |=> owner == 3'b001)
    else $error("general channel 0 not granted first");
  a_single_owner: assert property ($onehot0(owner))
    else $error("more than one owner");
  a_no_move_unacked: assert property (
    (state == pate_pkg::S_ASK) |-> !sys_bus.re && !sys_bus.we)
    else $error("bus access before acknowledge");
  a_read_then_write: assert property (
    sys_bus.re |-> ##2 (sys_bus.we && sys_bus.req))
    else $error("read not followed by write");
  a_periph_addr: assert property (
    (((sys_bus.re && gk.ctl.dir) || (sys_bus.we && !gk.ctl.dir))
      && !owner[2] && !bidx) |->
      sys_bus.addr == {pate_pkg::PERIPH_NIBBLE, gk.io})
    else $error("peripheral address wrong");
  a_addr_step: assert property (
    (done[0] && g_cur[0] != {g_regs[0].hi[7:4], g_regs[0].fin}
      && !g_regs[0].ctl.word && !(reg_wr && !reg_addr[4])) |=>
      g_cur[0] == $past(g_cur[0]) + pate_pkg::STEP_BYTE)
    else $error("current address did not step");
  a_end_reload: assert property (
    (done[0] && g_cur[0] == {g_regs[0].hi[7:4], g_regs[0].fin}
      && !(reg_wr && !reg_addr[4])) |=>
      g_cur[0] == {g_regs[0].hi[3:0], g_regs[0].start})
    else $error("start address not reloaded");
  a_end_irq: assert property (
    (done[0] && g_cur[0] == {g_regs[0].hi[7:4], g_regs[0].fin}
      && g_regs[0].ctl.irq_en) |=> irq_req[0] ##1 !irq_req[0])
    else $error("end interrupt missing");
  a_single_pass_off: assert property (
    (done[0] && g_cur[0] == {g_regs[0].hi[7:4], g_regs[0].fin}
      && !g_regs[0].ctl.loop && !(reg_wr && !reg_addr[4])) |=>
      !g_regs[0].ctl.en)
    else $error("single pass channel still enabled");
  a_adc_wrap: assert property (
    (done[2] && adc_input >= adc_ctl.last_in) |=>
      adc_start && adc_input == pate_pkg::ADC_IN_FIRST)
    else $error("converter input did not wrap");
  a_adc_next: assert property (
    (done[2] && adc_input < adc_ctl.last_in) |=>
      adc_start && adc_input == $past(adc_input) + 3'h1)
    else $error("converter input did not advance");
  a_adc_dest: assert property (
    (sys_bus.we && owner[2]) |->
      sys_bus.addr[11:5] == adc_base && sys_bus.addr[3:1] == adc_input)
    else $error("converter destination wrong");
  a_adc_irq: assert property (
    (done[2] && adc_input >= adc_ctl.last_in && adc_ctl.irq_en) |=>
      irq_req[2])
    else $error("converter wrap interrupt missing");

  c_gen_word: cover property (done[0] && g_regs[0].ctl.word);
  c_gen_wrap: cover property (irq_req[0]);
  c_adc_wrap: cover property (irq_req[2]);
  c_contend: cover property (g_pend[0] && adc_pend && state[0]);
endmodule
`default_nettype wire

// ---- dv/pate_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pate_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // system bus from the engine
  input wire pate_pkg::pate_sbus_t sys_bus,
  output logic bus_ack,
  output logic [7:0] sys_rdata,
  // grant latency and faults seen
  input wire logic [3:0] ack_delay,
  output logic [7:0] bad_cnt
);
  logic [7:0] mem [0:4095];
  logic [3:0] wait_cnt;
  // grant only after the chosen latency, hold it until req drops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
      wait_cnt <= 4'h0;
      bad_cnt <= 8'h00;
      sys_rdata <= 8'h00;
    end else begin
      if (!sys_bus.req) begin
        bus_ack <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
        bus_ack <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
      // bus moves without a grant are faults
      if ((sys_bus.re || sys_bus.we) && !bus_ack) begin
        bad_cnt <= bad_cnt + 8'h01;
      end
      // read data only in the cycle after re, scrambled otherwise
      if (sys_bus.re) begin
        sys_rdata <= mem[sys_bus.addr];
      end else begin
        sys_rdata <= ~sys_rdata;
      end
    end
  end
  // plain process: the bench also preloads this array
  always @(posedge core_clk) begin
    if (sys_bus.we && bus_ack) begin
      mem[sys_bus.addr] <= sys_bus.wdata;
    end
  end
endmodule
`default_nettype wire

// ---- dv/peripheral_adc_transfer_engine_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module peripheral_adc_transfer_engine_test;
  logic core_clk, rst, ce, reg_wr, reg_rd, adc_ready, adc_start, bus_ack;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sys_rdata, bad_cnt, d, b0, b1;
  logic [7:0] trig_in;
  logic [15:0] adc_data, data;
  logic [2:0] adc_input, irq_req;
  logic [3:0] ack_delay;
  logic [11:0] cur, a;
  pate_pkg::pate_sbus_t sys_bus;
  int error_cnt, n_checks, seed, j;
  int irq_cnt[3];
  logic [2:0] starts[$];

  pate_engine dut_u (.core_clk(core_clk), .rst(rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
    .adc_ready(adc_ready), .adc_data(adc_data), .adc_start(adc_start),
    .adc_input(adc_input), .bus_ack(bus_ack), .sys_rdata(sys_rdata),
    .sys_bus(sys_bus), .irq_req(irq_req));
  pate_core_model core_u (.core_clk(core_clk), .rst(rst),
    .sys_bus(sys_bus), .bus_ack(bus_ack), .sys_rdata(sys_rdata),
    .ack_delay(ack_delay), .bad_cnt(bad_cnt));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // registered pulses are sampled at the edge that ends them
  always @(posedge core_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (irq_req[k]) irq_cnt[k]++;
    end
    if (adc_start) starts.push_back(adc_input);
  end

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] ad, input logic [7:0] wd);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] ad, output logic [7:0] rd);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic pulse(input logic [7:0] m);
    ack_delay <= 4'($random(seed) & 7);
    @(posedge core_clk);
    trig_in <= m;
    @(posedge core_clk);
    trig_in <= 8'h00;
  endtask

  // one whole bus tenure, request up then down, bounded
  task automatic wait_xfer;
    int i;
    logic seen;
    i = 0;
    do begin
      @(posedge core_clk);
      #1;
      i++;
    end while (!sys_bus.req && i < 50);
    // a tenure that never starts or never ends is a failure
    seen = sys_bus.req;
    while (sys_bus.req && i < 100) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    chk_cnt(int'(!seen || sys_bus.req), 0);
  endtask

  function automatic logic [11:0] next_addr(logic [11:0] c, logic [11:0] e,
                                            logic [11:0] s, logic w);
    if (c == e) return s;
    return c + (w ? 12'h002 : 12'h001);
  endfunction

  initial begin
    {rst, ce, reg_wr, reg_rd, adc_ready} = 5'b11000;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    trig_in = 8'h00;
    adc_data = 16'h0000;
    ack_delay = 4'h0;
    seed = 32'hff4067b0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    for (int r = 0; r < 32; r++) begin
      reg_read(5'(r), d);
      chk8(d, 8'h00);
    end
    reg_write(5'h1f, 8'hff);
    reg_read(5'h1f, d);
    chk8(d, 8'h00);
    // general 0: bytes, register file to peripheral, single pass
    reg_write(5'h01, 8'h40);
    reg_write(5'h02, 8'h11);
    reg_write(5'h03, 8'h20);
    reg_write(5'h04, 8'h22);
    reg_write(5'h00, 8'h92);
    reg_read(5'h02, d);
    chk8(d, 8'h11);
    cur = 12'h120;
    for (int i = 0; i < 3; i++) begin
      core_u.mem[cur] = 8'($random(seed));
      b0 = core_u.mem[cur];
      pulse(8'h04);
      wait_xfer;
      chk8(core_u.mem[12'hf40], b0);
      cur = next_addr(cur, 12'h122, 12'h120, 1'b0);
      reg_read(5'h03, d);
      chk8(d, cur[7:0]);
    end
    chk_cnt(irq_cnt[0], 1);
    reg_read(5'h00, d);
    chk8(d, 8'h12);
    core_u.mem[12'h120] = ~b0;
    pulse(8'h04);
    repeat (30) @(posedge core_clk);
    chk8(core_u.mem[12'hf40], b0);
    // general 1: words, peripheral to register file, looping
    reg_write(5'h09, 8'h52);
    reg_write(5'h0a, 8'h22);
    reg_write(5'h0b, 8'h00);
    reg_write(5'h0c, 8'h02);
    reg_write(5'h08, 8'hfd);
    cur = 12'h200;
    for (int i = 0; i < 3; i++) begin
      core_u.mem[12'hf52] = 8'($random(seed));
      core_u.mem[12'hf53] = 8'($random(seed));
      b0 = core_u.mem[12'hf52];
      b1 = core_u.mem[12'hf53];
      pulse(8'h20);
      wait_xfer;
      chk8(core_u.mem[cur], b0);
      chk8(core_u.mem[cur + 12'h001], b1);
      cur = next_addr(cur, 12'h202, 12'h200, 1'b1);
      reg_read(5'h0b, d);
      chk8(d, cur[7:0]);
    end
    chk_cnt(irq_cnt[1], 1);
    // frozen engine must ignore this write
    @(posedge core_clk);
    ce <= 1'b0;
    reg_write(5'h08, 8'h00);
    ce <= 1'b1;
    reg_read(5'h08, d);
    chk8(d, 8'hfd);
    // both general channels at once under a random grant latency of 0 to 7
    reg_write(5'h00, 8'h92);
    reg_write(5'h08, 8'hed);
    pulse(8'h24);
    j = 0;
    do begin
      @(posedge core_clk);
      #1;
      j++;
    end while (!sys_bus.re && j < 50);
    chk8(sys_bus.addr[11:4], 8'h12);
    wait_xfer;
    wait_xfer;
    // converter: inputs 0..2, two passes
    reg_write(5'h10, 8'h30);
    reg_write(5'h11, 8'hc2);
    for (int i = 0; i < 6; i++) begin
      j = 0;
      while (starts.size() == 0 && j < 50) begin
        @(posedge core_clk);
        j++;
      end
      chk_cnt(starts.size(), 1);
      chk8({5'h00, starts.pop_front()}, 8'(i % 3));
      reg_read(5'h12, d);
      chk8(d, 8'(i % 3));
      data = 16'($random(seed));
      ack_delay <= 4'($random(seed) & 7);
      @(posedge core_clk);
      adc_data <= data;
      adc_ready <= 1'b1;
      @(posedge core_clk);
      adc_ready <= 1'b0;
      wait_xfer;
      repeat (3) @(posedge core_clk);
      a = {7'h30, 1'b0, 3'(i % 3), 1'b0};
      chk8(core_u.mem[a], data[15:8]);
      chk8(core_u.mem[a + 12'h001], data[7:0]);
    end
    chk_cnt(irq_cnt[2], 2);
    chk_cnt(irq_cnt[1], 1);
    chk8(bad_cnt, 8'h00);
    final_report;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    final_report;
  end
endmodule
`default_nettype wire
